// file: rtl/qts_pkg.sv
package qts_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_REQ = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_COUNT_EN = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h6;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h7;
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EVT_MASK = 4'h9;
  // mode register fields
  localparam int MODE_START_BIT = 7;
  localparam int MODE_PHASE_BIT = 1;
  localparam int MODE_PWM_BIT = 0;
  // status register fields
  localparam int STAT_DIR_BIT = 4;
  localparam int STAT_OVF_BIT = 3;
  localparam int STAT_UDF_BIT = 2;
  localparam int STAT_MATCH_B_BIT = 1;
  localparam int STAT_MATCH_A_BIT = 0;
  // interrupt request, mask and enable fields
  localparam int IRQ_TIMER_BIT = 3;
  localparam int IEN_OVF_BIT = 3;
  localparam int IEN_UDF_BIT = 2;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] COUNT_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] READ_DEFAULT = 8'h00;
  // events for the sticky event status register
  localparam int EVT_OVF_BIT = 0;
  localparam int EVT_UDF_BIT = 1;
  localparam int EVT_IRQ_BIT = 2;
endpackage : qts_pkg

// file: rtl/qts_flag_clear_if.sv
`timescale 1ns/100ps
interface qts_flag_clear_if;
  logic read_seen;
  logic write_zero;
  logic clear;
  modport top (output read_seen, output write_zero, input clear);
  modport arm (input read_seen, input write_zero, output clear);
endinterface : qts_flag_clear_if

// file: rtl/qts_flag_clear.sv
`timescale 1ns/100ps
// arms on a read that saw the flag at 1, clears on a later zero write
module qts_flag_clear (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // flag state
  input wire logic i_flag,
  // sequence signals
  qts_flag_clear_if.arm port
);
  logic armed_reg;
  logic armed_next;

  assign port.clear = port.write_zero & armed_reg;
  // a zero write drops the arm, so an event set in the clearing cycle needs a fresh read
  assign armed_next = port.read_seen ? i_flag :
                      (port.write_zero ? 1'b0 : armed_reg & i_flag);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end
endmodule : qts_flag_clear

// file: rtl/qts_timer.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Writing 1 to mode bit 7 starts the counter on the phase inputs.
// [R2] Mode bit 7 at 0 stops counting and, in PWM mode, resets the PWM pin.
// [R3] Status bit 3 overflow clears only by a read of it then a zero write.
// [R4] Status bit 2 underflow clears only by a read of it then a zero write.
// [R5] Status holds direction 4, overflow 3, underflow 2, matches 1 and 0; here bits 1 and 0 always read 0.
// [R6] Request bit 3 reads 1 while pending, and software clears it with 0.
// [R7] Mask bit 3 at 0 passes the request to the processor, at 1 blocks it.
// [R8] Software clears flags and request, unmasks, and only then starts.
// [R9] Mode bit 1 picks plain increment at 0 and phase counting at 1.
// [R10] Enable bits 7..4 pick increment edges, bits 3..0 decrement edges.
// [R11] Overflow or underflow raises the request only if its enable is 1.
// [R12] A zero write without a prior read of the flag as 1 keeps the flag.
module qts_timer #(
  parameter int COUNT_WIDTH = 16
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // encoder phase inputs
  input wire logic I_PHASE_INPUT_A,
  input wire logic I_PHASE_INPUT_B,
  // pwm output pin
  output logic O_PWM_OUTPUT_PIN,
  // interrupts
  output logic O_TIMER_INTERRUPT,
  output logic O_IRQ
);
  // refused at elaboration: the count bytes map onto two 8-bit reads
  if (COUNT_WIDTH < 9 || COUNT_WIDTH > 16) begin : g_width_check
    $error("COUNT_WIDTH must be 9..16");
  end

  typedef enum logic [1:0] {QTS_IDLE, QTS_RUN} qts_run_t;

  function automatic logic [7:0] qts_byte(input logic [15:0] v,
                                          input logic hi);
    qts_byte = hi ? v[15:8] : v[7:0];
  endfunction : qts_byte

  localparam logic [COUNT_WIDTH-1:0] CNT_MAX = {COUNT_WIDTH{1'b1}};
  localparam logic [COUNT_WIDTH-1:0] CNT_ONE =
    {{(COUNT_WIDTH-1){1'b0}}, 1'b1};

  // pin synchronisers
  logic [1:0] sync_a_reg;
  logic [1:0] sync_b_reg;
  logic prev_a_reg;
  logic prev_b_reg;

  // registers
  logic [7:0] mode_reg;
  logic [7:0] count_en_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] irq_req_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] evt_status_reg;
  logic [7:0] evt_mask_reg;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  logic ovf_reg;
  logic udf_reg;
  logic dir_reg;
  logic pwm_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  qts_run_t run_reg;
  qts_run_t run_next;

  // decode
  wire wr_mode = I_WR && I_ADDR == qts_pkg::ADDR_MODE;
  wire wr_status = I_WR && I_ADDR == qts_pkg::ADDR_STATUS;
  wire wr_irq_req = I_WR && I_ADDR == qts_pkg::ADDR_IRQ_REQ;
  wire wr_irq_mask = I_WR && I_ADDR == qts_pkg::ADDR_IRQ_MASK;
  wire wr_count_en = I_WR && I_ADDR == qts_pkg::ADDR_COUNT_EN;
  wire wr_irq_en = I_WR && I_ADDR == qts_pkg::ADDR_IRQ_EN;
  wire wr_evt_status = I_WR && I_ADDR == qts_pkg::ADDR_EVT_STATUS;
  wire wr_evt_mask = I_WR && I_ADDR == qts_pkg::ADDR_EVT_MASK;
  wire rd_status = I_RD && I_ADDR == qts_pkg::ADDR_STATUS;

  // phase edge and level detection on the second synchroniser stage
  wire a_now = sync_a_reg[1];
  wire b_now = sync_b_reg[1];
  wire a_rise = a_now & ~prev_a_reg;
  wire a_fall = ~a_now & prev_a_reg;
  wire b_rise = b_now & ~prev_b_reg;
  wire b_fall = ~b_now & prev_b_reg;
  wire [7:0] cond;
  assign cond[7] = ~a_now & b_rise;
  assign cond[6] = b_now & a_rise;
  assign cond[5] = a_now & b_fall;
  assign cond[4] = ~b_now & a_fall;
  assign cond[3] = b_now & a_fall;
  assign cond[2] = ~a_now & b_fall;
  assign cond[1] = ~b_now & a_rise;
  assign cond[0] = a_now & b_rise;
  wire [7:0] cond_en = cond & count_en_reg;
  wire running = run_reg == QTS_RUN;
  wire phase_mode = mode_reg[qts_pkg::MODE_PHASE_BIT];
  // both an up and a down condition in one cycle cancel
  wire up_raw = phase_mode ? |cond_en[7:4] : 1'b1; // [R9] [R10]
  wire dn_raw = phase_mode ? |cond_en[3:0] : 1'b0; // [R10]
  wire step_up = running & up_raw & ~dn_raw;
  wire step_dn = running & dn_raw & ~up_raw;
  wire ovf_evt = step_up & (count_reg == CNT_MAX);
  wire udf_evt = step_dn & (count_reg == '0);

  // flag clear sequencing
  qts_flag_clear_if ovf_if();
  qts_flag_clear_if udf_if();
  assign ovf_if.read_seen = rd_status;
  assign udf_if.read_seen = rd_status;
  assign ovf_if.write_zero = wr_status & ~I_WDATA[qts_pkg::STAT_OVF_BIT];
  assign udf_if.write_zero = wr_status & ~I_WDATA[qts_pkg::STAT_UDF_BIT];

  qts_flag_clear u_ovf_clear (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_flag(ovf_reg),
    .port(ovf_if.arm)
  );

  qts_flag_clear u_udf_clear (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_flag(udf_reg),
    .port(udf_if.arm)
  );

  // set wins over clear; unarmed zero writes leave the flag alone
  wire ovf_next = ovf_evt | (ovf_reg & ~ovf_if.clear); // [R3] [R12]
  wire udf_next = udf_evt | (udf_reg & ~udf_if.clear); // [R4] [R12]

  wire req_set = (ovf_evt & irq_en_reg[qts_pkg::IEN_OVF_BIT]) |
                 (udf_evt & irq_en_reg[qts_pkg::IEN_UDF_BIT]); // [R11]
  wire [7:0] irq_req_next;
  assign irq_req_next = wr_irq_req ? I_WDATA : irq_req_reg;
  wire req_bit_next = req_set |
    (wr_irq_req ? I_WDATA[qts_pkg::IRQ_TIMER_BIT]
                : irq_req_reg[qts_pkg::IRQ_TIMER_BIT]); // [R6]

  // request reaches the processor only while unmasked
  wire timer_int = irq_req_reg[qts_pkg::IRQ_TIMER_BIT] &
                   ~irq_mask_reg[qts_pkg::IRQ_TIMER_BIT]; // [R7]

  wire [7:0] evt_raw;
  assign evt_raw = {5'h0_0, req_set, udf_evt, ovf_evt};
  wire [7:0] evt_status_next =
    evt_raw | (evt_status_reg & ~(wr_evt_status ? I_WDATA : 8'h00));

  always_comb begin
    run_next = run_reg;
    case (run_reg)
      QTS_IDLE: begin
        if (mode_reg[qts_pkg::MODE_START_BIT]) begin
          run_next = QTS_RUN; // [R1]
        end
      end
      QTS_RUN: begin
        if (!mode_reg[qts_pkg::MODE_START_BIT]) begin
          run_next = QTS_IDLE; // [R2]
        end
      end
      default: run_next = QTS_IDLE;
    endcase
  end

  always_comb begin
    count_next = count_reg;
    if (step_up) begin
      count_next = count_reg + CNT_ONE;
    end else if (step_dn) begin
      count_next = count_reg - CNT_ONE;
    end
  end

  wire [15:0] count_wide = 16'(count_reg);
  wire [7:0] status_val = {3'h0, dir_reg, ovf_reg, udf_reg,
                           2'h0}; // [R5]

  always_comb begin
    case (I_ADDR)
      qts_pkg::ADDR_MODE: rdata_next = mode_reg;
      qts_pkg::ADDR_STATUS: rdata_next = status_val;
      qts_pkg::ADDR_IRQ_REQ: rdata_next = irq_req_reg;
      qts_pkg::ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
      qts_pkg::ADDR_COUNT_EN: rdata_next = count_en_reg;
      qts_pkg::ADDR_IRQ_EN: rdata_next = irq_en_reg;
      qts_pkg::ADDR_COUNT_LO: rdata_next = qts_byte(count_wide, 1'b0);
      qts_pkg::ADDR_COUNT_HI: rdata_next = qts_byte(count_wide, 1'b1);
      qts_pkg::ADDR_EVT_STATUS: rdata_next = evt_status_reg;
      qts_pkg::ADDR_EVT_MASK: rdata_next = evt_mask_reg;
      default: rdata_next = qts_pkg::READ_DEFAULT;
    endcase
    if (!I_RD) begin
      rdata_next = qts_pkg::READ_DEFAULT;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sync_a_reg <= 2'h0;
      sync_b_reg <= 2'h0;
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end else begin
      sync_a_reg <= {sync_a_reg[0], I_PHASE_INPUT_A};
      sync_b_reg <= {sync_b_reg[0], I_PHASE_INPUT_B};
      prev_a_reg <= a_now;
      prev_b_reg <= b_now;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      mode_reg <= qts_pkg::MODE_RESET;
      count_en_reg <= qts_pkg::COUNT_EN_RESET;
      irq_en_reg <= qts_pkg::IRQ_EN_RESET;
      irq_mask_reg <= qts_pkg::MASK_RESET;
      evt_mask_reg <= qts_pkg::MASK_RESET;
    end else begin
      if (wr_mode) mode_reg <= I_WDATA;
      if (wr_count_en) count_en_reg <= I_WDATA;
      if (wr_irq_en) irq_en_reg <= I_WDATA;
      if (wr_irq_mask) irq_mask_reg <= I_WDATA;
      if (wr_evt_mask) evt_mask_reg <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      run_reg <= QTS_IDLE;
      count_reg <= COUNT_WIDTH'(qts_pkg::COUNT_RESET);
      ovf_reg <= 1'b0;
      udf_reg <= 1'b0;
      dir_reg <= 1'b0;
      irq_req_reg <= 8'h00;
      evt_status_reg <= 8'h00;
      rdata_reg <= qts_pkg::READ_DEFAULT;
    end else begin
      run_reg <= run_next;
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      udf_reg <= udf_next;
      if (step_up | step_dn) dir_reg <= step_up;
      irq_req_reg <= {irq_req_next[7:4], req_bit_next, irq_req_next[2:0]};
      evt_status_reg <= evt_status_next;
      rdata_reg <= rdata_next;
    end
  end

  // pwm waveform itself is out of scope; stop returns the pin to idle low
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pwm_reg <= 1'b0;
    end else if (!mode_reg[qts_pkg::MODE_START_BIT]) begin
      // a stop that also drops the pwm select must not leave the pin high
      pwm_reg <= 1'b0; // [R2]
    end else if (mode_reg[qts_pkg::MODE_PWM_BIT] && ovf_evt) begin
      pwm_reg <= ~pwm_reg;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_PWM_OUTPUT_PIN = pwm_reg;
  assign O_TIMER_INTERRUPT = timer_int;
  assign O_IRQ = |(evt_status_reg & ~evt_mask_reg);
endmodule : qts_timer

// file: tb/qts_timer_monitor.sv
`timescale 1ns/100ps
module qts_timer_monitor #(
  parameter int COUNT_WIDTH = 16
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // pins
  input wire logic O_PWM_OUTPUT_PIN,
  input wire logic O_TIMER_INTERRUPT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  status_bits_a: assert property (
    $past(I_RD && I_ADDR == qts_pkg::ADDR_STATUS)
    |-> O_RDATA[7:5] == 3'b000 && O_RDATA[1:0] == 2'b00)
    else $error("status spare bits set");
  ovf_hold_a: assert property (
    (I_RD && I_ADDR == qts_pkg::ADDR_STATUS) ##1 (O_RDATA[3] && !I_WR)
    ##1 (I_RD && I_ADDR == qts_pkg::ADDR_STATUS) |=> O_RDATA[3])
    else $error("overflow lost without write");
  mask_block_a: assert property (
    I_WR && I_ADDR == qts_pkg::ADDR_IRQ_MASK && I_WDATA[3]
    |=> !O_TIMER_INTERRUPT)
    else $error("masked interrupt passed");
  mask_read_a: assert property (
    $past(I_RD && I_ADDR == qts_pkg::ADDR_IRQ_MASK && O_TIMER_INTERRUPT)
    |-> !O_RDATA[3])
    else $error("interrupt with mask set");
  req_read_a: assert property (
    $past(I_RD && I_ADDR == qts_pkg::ADDR_IRQ_REQ && O_TIMER_INTERRUPT)
    |-> O_RDATA[3])
    else $error("interrupt without request");
  stop_pwm_a: assert property (
    I_WR && I_ADDR == qts_pkg::ADDR_MODE && !I_WDATA[7]
    |-> ##[1:4] !O_PWM_OUTPUT_PIN)
    else $error("pwm pin not reset on stop");
  mode_back_a: assert property (
    (I_WR && I_ADDR == qts_pkg::ADDR_MODE) ##1
    (I_RD && I_ADDR == qts_pkg::ADDR_MODE)
    |=> O_RDATA[7] == $past(I_WDATA[7], 2))
    else $error("start bit readback wrong");
  unmapped_read_a: assert property (
    $past(I_RD && I_ADDR > qts_pkg::ADDR_EVT_MASK) |-> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule : qts_timer_monitor
bind qts_timer qts_timer_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) u_mon (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_PWM_OUTPUT_PIN(O_PWM_OUTPUT_PIN),
  .O_TIMER_INTERRUPT(O_TIMER_INTERRUPT)
);

// file: tb/qts_encoder_model.sv
`timescale 1ns/100ps
// one quadrature edge per step request; phases hold between steps
module qts_encoder_model (
  // clock, step requests and phases
  input wire logic i_clk,
  input wire logic i_up,
  input wire logic i_dn,
  output logic o_a,
  output logic o_b
);
  logic [1:0] pos_reg = 2'b00;
  always @(posedge i_clk) begin
    if (i_up) pos_reg <= pos_reg + 2'b01;
    else if (i_dn) pos_reg <= pos_reg - 2'b01;
  end
  // upward order of a, b is 00, 01, 11, 10
  assign o_a = pos_reg[1];
  assign o_b = pos_reg[1] ^ pos_reg[0];
endmodule : qts_encoder_model

// file: tb/test_quadrature_timer_start_status.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
`define CHKL(n, e, s) begin @(negedge clk); `CHK(n, e, s) @(posedge clk); end
module test_quadrature_timer_start_status;
  typedef struct packed {
    logic we; logic [3:0] a; logic [7:0] d; logic [7:0] e;
  } qts_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic [7:0] rdata, v, c0;
  logic pa, pb, pwm, tint, irq;
  int error_cnt = 0;
  int checks = 0;
  int i;
  // reset values, then setup in the order software must follow
  qts_row_t rows [16] = '{
    {1'b0, 4'h0, 8'h00, 8'h00}, {1'b0, 4'h3, 8'h00, 8'hFF},
    {1'b0, 4'h4, 8'h00, 8'h00}, {1'b0, 4'h5, 8'h00, 8'h00},
    {1'b0, 4'h1, 8'h00, 8'h00}, {1'b0, 4'h2, 8'h00, 8'h00},
    {1'b0, 4'h8, 8'h00, 8'h00}, {1'b0, 4'hA, 8'h00, 8'h00},
    {1'b1, 4'hC, 8'h5A, 8'h00}, {1'b1, 4'h1, 8'h00, 8'h00},
    {1'b1, 4'h2, 8'h00, 8'h00}, {1'b1, 4'h3, 8'hF7, 8'hF7},
    {1'b1, 4'h5, 8'h08, 8'h08}, {1'b1, 4'h9, 8'h00, 8'h00},
    {1'b1, 4'h4, 8'h0F, 8'h0F}, {1'b1, 4'h0, 8'h80, 8'h80}};
  always #50 clk = ~clk;
  // short counter so that overflow comes within a few hundred cycles
  qts_timer #(.COUNT_WIDTH(9)) dut (.I_CLK_SYS(clk), .I_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(we), .I_RD(re), .O_RDATA(rdata),
    .I_PHASE_INPUT_A(pa), .I_PHASE_INPUT_B(pb), .O_PWM_OUTPUT_PIN(pwm),
    .O_TIMER_INTERRUPT(tint), .O_IRQ(irq));
  qts_encoder_model enc (.i_clk(clk), .i_up(up), .i_dn(dn), .o_a(pa),
    .o_b(pb));
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // a strobe still pending from the last call costs one gap cycle
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    if (we) @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : bus_rd
  task automatic step(input logic u);
    up <= u;
    dn <= !u;
    @(posedge clk);
    up <= 1'b0;
    dn <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : step
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[k]) begin
      if (rows[k].we) bus_wr(rows[k].a, rows[k].d);
      bus_rd(rows[k].a, v);
      `CHK("row", rows[k].e, v)
    end
    for (i = 0; i < 800 && tint !== 1'b1; i++) @(posedge clk);
    `CHKL("ovf int", 1'b1, tint)
    bus_wr(4'h0, 8'h00);
    repeat (3) @(posedge clk);
    bus_rd(4'h6, c0);
    repeat (8) @(posedge clk);
    bus_rd(4'h6, v);
    `CHK("stopped", c0, v)
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h1, v);
    `CHK("ovf kept", 1'b1, v[3])
    `CHK("dir up", 1'b1, v[4])
    bus_rd(4'h1, v);
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h1, v);
    `CHK("ovf clr", 1'b0, v[3])
    bus_rd(4'h2, v);
    `CHK("req", 1'b1, v[3])
    bus_wr(4'h3, 8'hFF);
    `CHKL("masked", 1'b0, tint)
    bus_wr(4'h3, 8'hF7);
    `CHKL("unmasked", 1'b1, tint)
    bus_rd(4'h3, v);
    bus_rd(4'h8, v);
    `CHK("events", 3'b101, v[2:0])
    `CHKL("irq", 1'b1, irq)
    bus_wr(4'h8, 8'h07);
    bus_wr(4'h2, 8'h00);
    `CHKL("irq clr", 1'b0, irq)
    `CHKL("req clr", 1'b0, tint)
    bus_wr(4'h0, 8'h81);
    for (i = 0; i < 800 && pwm !== 1'b1; i++) @(posedge clk);
    `CHKL("pwm on", 1'b1, pwm)
    bus_wr(4'h0, 8'h00);
    repeat (3) @(posedge clk);
    `CHKL("pwm off", 1'b0, pwm)
    bus_rd(4'h1, v);
    bus_wr(4'h1, 8'h00);
    bus_wr(4'h4, 8'hF0);
    bus_wr(4'h0, 8'h82);
    bus_rd(4'h6, c0);
    repeat (4) step(1'b1);
    bus_rd(4'h6, v);
    `CHK("count up", c0 + 8'h04, v)
    repeat (4) step(1'b0);
    bus_rd(4'h6, v);
    `CHK("no down", c0 + 8'h04, v)
    bus_wr(4'h4, 8'h0F);
    bus_wr(4'h2, 8'h00);
    v = 8'h00;
    for (i = 0; i < 600 && v[2] !== 1'b1; i++) begin
      step(1'b0);
      bus_rd(4'h1, v);
    end
    `CHK("udf", 1'b1, v[2])
    `CHK("dir dn", 1'b0, v[4])
    `CHKL("udf no req", 1'b0, tint)
    bus_rd(4'h6, v);
    `CHK("wrap", 8'hFF, v)
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h1, v);
    `CHK("udf clr", 1'b0, v[2])
    // second reset in mid-run, with events pending and unmasked
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_rd(4'h3, v);
    `CHK("mask rst", 8'hFF, v)
    bus_rd(4'h1, v);
    `CHK("status rst", 8'h00, v)
    `CHKL("irq rst", 1'b0, irq)
    `CHKL("int rst", 1'b0, tint)
    `CHKL("pwm rst", 1'b0, pwm)
    final_report();
  end
endmodule : test_quadrature_timer_start_status
